// File: rtl/clock_generator_pkg.sv
package clock_generator_pkg;
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // Register byte addresses
  localparam logic [7:0] CTRL1_OFS = 8'h00;
  localparam logic [7:0] CTRL2_OFS = 8'h04;
  localparam logic [7:0] TRIM_OFS = 8'h08;
  localparam logic [7:0] LOOP_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;

  // Control 1 fields
  localparam int SOURCE_SELECT_POS = 6;
  localparam int REF_DIVIDER_POS = 3;
  localparam int REF_SELECT_POS = 2;
  localparam int IRCLKEN_POS = 1;
  localparam int IREFSTEN_POS = 0;
  localparam logic [7:0] CTRL1_RST = 8'h04;
  // Control 2 fields
  localparam int BUS_DIVIDER_POS = 6;
  localparam int RANGE_POS = 5;
  localparam int HGO_POS = 4;
  localparam int LP_POS = 3;
  localparam int EREFS_POS = 2;
  localparam int CME_POS = 1;
  localparam logic [7:0] CTRL2_RST = 8'h40;
  // Trim and loop
  localparam int TRIM_W = 9;
  localparam logic [8:0] TRIM_RST = 9'h100;
  localparam int PLLS_POS = 0;
  localparam int MULT_POS = 8;
  localparam logic [7:0] MULT_RST = 8'h20;
  localparam logic [7:0] DCO_ADJ_RST = 8'h80;
  // Status fields
  localparam int ST_MODE_POS = 0;
  localparam int ST_LOCK_POS = 4;
  localparam int ST_OSCRDY_POS = 5;
  localparam int ST_IREFST_POS = 6;
  localparam int ST_CLKST_POS = 7;
  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_UNLOCK = 1;
  localparam int IRQ_EXTLOSS = 2;

  // Clock select codes
  localparam logic [1:0] SEL_LOOP = 2'h0;
  localparam logic [1:0] SEL_INT = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;
  localparam logic [1:0] SRC_DCO = 2'h0;
  localparam logic [1:0] SRC_VCO = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Lock detection and clock monitor timing
  localparam logic [7:0] LOCK_TOL = 8'h02;
  localparam logic [3:0] LOCK_COUNT = 4'h4;
  localparam int EXT_LOSS_TIME_NS = 100_000;
  localparam int EXT_LOSS_CYCLES = (EXT_LOSS_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [3:0] {
    fll_engaged_internal = 4'h0,
    fll_engaged_external = 4'h1,
    fll_bypassed_internal = 4'h2,
    fll_bypassed_external = 4'h3,
    pll_engaged_external = 4'h4,
    pll_bypassed_external = 4'h5,
    low_power_bypass_internal = 4'h6,
    low_power_bypass_external = 4'h7,
    stop_mode = 4'h8
  } mode_t;
endpackage

// File: rtl/clk_edge_if.sv
`timescale 1ns/1ns
interface clk_edge_if;
  logic level;
  logic rise;
  logic toggle;
  modport source(output level, output rise, output toggle);
  modport sink(input level, input rise, input toggle);
endinterface

// File: rtl/edge_tracker.sv
`timescale 1ns/1ns
module edge_tracker #(
  parameter int STAGES = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin,
  clk_edge_if.source edges
);
  logic [STAGES:0] sync_reg;

  initial begin
    if (STAGES < 2) begin
      $error("edge_tracker needs at least two stages");
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[STAGES-1:0], pin};
    end
  end

  assign edges.level = sync_reg[STAGES-1];
  assign edges.rise = sync_reg[STAGES-1] & ~sync_reg[STAGES];
  assign edges.toggle = sync_reg[STAGES-1] ^ sync_reg[STAGES];
endmodule

// File: rtl/clock_generator.sv
`timescale 1ns/1ns
module clock_generator #(
  parameter int MULT_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [clock_generator_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [clock_generator_pkg::DAT_W-1:0] wb_dat_i,
  output logic [clock_generator_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic int_ref_clk,
  input wire logic ext_ref_clk,
  input wire logic dco_clk,
  input wire logic vco_clk,
  input wire logic osc_ready,
  input wire logic stop_req,
  output logic sys_clk,
  output logic debug_half_rate_clock,
  output logic [clock_generator_pkg::TRIM_W-1:0] int_ref_trim,
  output logic int_ref_enable,
  output logic osc_enable,
  output logic osc_range,
  output logic osc_high_gain,
  output logic fll_enable,
  output logic pll_enable,
  output logic [MULT_W-1:0] dco_adjust,
  output logic [MULT_W-1:0] vco_divide,
  output logic irq,
  output logic ext_loss_reset_req
);
  import clock_generator_pkg::*;

  initial begin
    if (MULT_W != 8) begin
      $error("clock_generator supports MULT_W of 8 only");
    end
  end

  // Source edge trackers; all inputs stay on chip
  clk_edge_if int_e();
  clk_edge_if ext_e();
  clk_edge_if dco_e();
  clk_edge_if vco_e();
  clk_edge_if rdy_e();
  edge_tracker #(.STAGES(2)) u_int (.ref_clk(ref_clk), .rst_n(rst_n), .pin(int_ref_clk),
    .edges(int_e));
  edge_tracker #(.STAGES(2)) u_ext (.ref_clk(ref_clk), .rst_n(rst_n), .pin(ext_ref_clk),
    .edges(ext_e));
  edge_tracker #(.STAGES(2)) u_dco (.ref_clk(ref_clk), .rst_n(rst_n), .pin(dco_clk),
    .edges(dco_e));
  edge_tracker #(.STAGES(2)) u_vco (.ref_clk(ref_clk), .rst_n(rst_n), .pin(vco_clk),
    .edges(vco_e));
  edge_tracker #(.STAGES(2)) u_rdy (.ref_clk(ref_clk), .rst_n(rst_n), .pin(osc_ready),
    .edges(rdy_e));

  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [TRIM_W-1:0] trim_reg;
  logic plls_reg;
  logic [MULT_W-1:0] mult_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [DAT_W-1:0] rd_data;
  logic [DAT_W-1:0] byte_mask;
  logic [DAT_W-1:0] status_word;
  logic wr_stb;
  mode_t mode;
  mode_t run_mode_reg;
  logic lock_reg;
  logic [1:0] src_act_reg;

  // Field views
  logic [1:0] source_select_field;
  logic [2:0] reference_divider_field;
  logic reference_select_bit;
  logic [1:0] bus_divider_field;
  logic lp;
  assign source_select_field = (ctrl1_reg[SOURCE_SELECT_POS+:2] == 2'h3) ? SEL_LOOP :
    ctrl1_reg[SOURCE_SELECT_POS+:2];
  assign reference_divider_field = ctrl1_reg[REF_DIVIDER_POS+:3];
  assign reference_select_bit = ctrl1_reg[REF_SELECT_POS];
  assign bus_divider_field = ctrl2_reg[BUS_DIVIDER_POS+:2];
  assign lp = ctrl2_reg[LP_POS];

  // Mode decode
  always_comb begin
    mode = fll_engaged_internal;
    if (stop_req) begin
      mode = stop_mode;
    end else begin
      case (source_select_field)
        SEL_INT: mode = lp ? low_power_bypass_internal : fll_bypassed_internal;
        SEL_EXT: begin
          if (lp) begin
            mode = low_power_bypass_external;
          end else begin
            mode = plls_reg ? pll_bypassed_external : fll_bypassed_external;
          end
        end
        default: begin
          if (plls_reg) begin
            mode = pll_engaged_external;
          end else begin
            mode = reference_select_bit ? fll_engaged_internal : fll_engaged_external;
          end
        end
      endcase
    end
  end

  // Wishbone slave
  logic wb_req;
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wr_stb = wb_req & wb_we_i & wb_ack_o;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_val,
      input logic [DAT_W-1:0] new_val, input logic [DAT_W-1:0] m);
    merge = (old_val & ~m) | (new_val & m);
  endfunction

  always_comb begin
    status_word = '0;
    status_word[ST_MODE_POS+:4] = mode;
    status_word[ST_LOCK_POS] = lock_reg;
    status_word[ST_OSCRDY_POS] = rdy_e.level;
    status_word[ST_IREFST_POS] = reference_select_bit;
    status_word[ST_CLKST_POS+:2] = src_act_reg;
  end

  always_comb begin
    rd_data = '0;
    if (wb_adr_i == CTRL1_OFS) begin
      rd_data[7:0] = ctrl1_reg;
    end else if (wb_adr_i == CTRL2_OFS) begin
      rd_data[7:0] = ctrl2_reg;
    end else if (wb_adr_i == TRIM_OFS) begin
      rd_data[TRIM_W-1:0] = trim_reg;
    end else if (wb_adr_i == LOOP_OFS) begin
      rd_data[PLLS_POS] = plls_reg;
      rd_data[MULT_POS+:MULT_W] = mult_reg;
    end else if (wb_adr_i == STATUS_OFS) begin
      rd_data = status_word;
    end else if (wb_adr_i == IRQ_STAT_OFS) begin
      rd_data[IRQ_W-1:0] = irq_stat_reg;
    end else if (wb_adr_i == IRQ_MASK_OFS) begin
      rd_data[IRQ_W-1:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= (wb_req & ~wb_ack_o) ? rd_data : '0;
    end
  end

  // Configuration registers
  logic [DAT_W-1:0] wr_val;
  always_comb begin
    wr_val = '0;
    if (wb_adr_i == CTRL1_OFS) begin
      wr_val = merge({24'h000000, ctrl1_reg}, wb_dat_i, byte_mask);
    end else if (wb_adr_i == CTRL2_OFS) begin
      wr_val = merge({24'h000000, ctrl2_reg[7:1], 1'b0} | {31'h0, ctrl2_reg[0]},
        wb_dat_i, byte_mask);
    end else if (wb_adr_i == TRIM_OFS) begin
      wr_val = merge({23'h000000, trim_reg}, wb_dat_i, byte_mask);
    end else if (wb_adr_i == LOOP_OFS) begin
      wr_val = merge({16'h0000, mult_reg, 7'h00, plls_reg}, wb_dat_i, byte_mask);
    end else if (wb_adr_i == IRQ_MASK_OFS) begin
      wr_val = merge({29'h0, irq_mask_reg}, wb_dat_i, byte_mask);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_reg <= CTRL1_RST;
      ctrl2_reg <= CTRL2_RST;
      trim_reg <= TRIM_RST;
      plls_reg <= 1'b0;
      mult_reg <= MULT_RST;
      irq_mask_reg <= '0;
    end else if (wr_stb) begin
      if (wb_adr_i == CTRL1_OFS) begin
        ctrl1_reg <= wr_val[7:0];
      end else if (wb_adr_i == CTRL2_OFS) begin
        ctrl2_reg <= wr_val[7:0];
      end else if (wb_adr_i == TRIM_OFS) begin
        trim_reg <= wr_val[TRIM_W-1:0];
      end else if (wb_adr_i == LOOP_OFS) begin
        plls_reg <= wr_val[PLLS_POS];
        mult_reg <= wr_val[MULT_POS+:MULT_W];
      end else if (wb_adr_i == IRQ_MASK_OFS) begin
        irq_mask_reg <= wr_val[IRQ_W-1:0];
      end
    end
  end

  // Reference divider ahead of the loops
  logic ref_rise;
  logic ref_tick;
  logic [6:0] ref_cnt_reg;
  logic [6:0] ref_last;
  assign ref_rise = reference_select_bit ? int_e.rise : ext_e.rise;
  assign ref_last = 7'((8'h01 << reference_divider_field) - 8'h01);
  assign ref_tick = ref_rise & (ref_cnt_reg == ref_last);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_reg <= '0;
    end else if (ref_rise) begin
      ref_cnt_reg <= (ref_cnt_reg >= ref_last) ? 7'h00 : ref_cnt_reg + 7'h01;
    end
  end

  // Loop edge counting per reference tick
  logic loop_rise;
  logic [MULT_W-1:0] loop_cnt_reg;
  logic [MULT_W-1:0] diff;
  logic in_window;
  assign loop_rise = plls_reg ? vco_e.rise : dco_e.rise;
  assign diff = (loop_cnt_reg > mult_reg) ? loop_cnt_reg - mult_reg : mult_reg - loop_cnt_reg;
  assign in_window = diff <= LOCK_TOL;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_cnt_reg <= '0;
    end else if (ref_tick) begin
      loop_cnt_reg <= '0;
    end else if (loop_rise && loop_cnt_reg != {MULT_W{1'b1}}) begin
      loop_cnt_reg <= loop_cnt_reg + 8'h01;
    end
  end

  // FLL frequency steering of the oscillator core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dco_adjust <= DCO_ADJ_RST;
    end else if (ref_tick && !plls_reg && fll_enable) begin
      if (loop_cnt_reg < mult_reg && dco_adjust != {MULT_W{1'b1}}) begin
        dco_adjust <= dco_adjust + 8'h01;
      end else if (loop_cnt_reg > mult_reg && dco_adjust != '0) begin
        dco_adjust <= dco_adjust - 8'h01;
      end
    end
  end

  // PLL lock detector
  logic [3:0] lock_run_reg;
  logic lock_gain;
  logic lock_lose;
  assign lock_gain = pll_enable & ref_tick & in_window & ~lock_reg &
    (lock_run_reg == LOCK_COUNT - 4'h1);
  assign lock_lose = lock_reg & (~pll_enable | (ref_tick & ~in_window));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
      lock_run_reg <= '0;
    end else if (lock_lose || !pll_enable) begin
      lock_reg <= 1'b0;
      lock_run_reg <= '0;
    end else if (ref_tick) begin
      lock_run_reg <= in_window ? ((lock_run_reg == LOCK_COUNT) ? lock_run_reg :
        lock_run_reg + 4'h1) : 4'h0;
      if (lock_gain) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // External clock monitor
  logic [11:0] loss_cnt_reg;
  logic ext_loss;
  logic mon_on;
  assign mon_on = ctrl2_reg[CME_POS] & osc_enable & (mode != stop_mode);
  assign ext_loss = mon_on & (loss_cnt_reg == 12'(EXT_LOSS_CYCLES - 1)) & ~ext_e.toggle;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_cnt_reg <= '0;
    end else if (!mon_on || ext_e.toggle || ext_loss) begin
      loss_cnt_reg <= '0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_loss_reset_req <= 1'b0;
    end else if (ext_loss) begin
      ext_loss_reset_req <= 1'b1;
    end
  end

  // Interrupt status, set wins over clear
  assign irq_set = {ext_loss, lock_lose, lock_gain};
  assign irq_clr = (wr_stb && wb_adr_i == IRQ_STAT_OFS && wb_sel_i[0]) ?
    wb_dat_i[IRQ_W-1:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Loop, reference and oscillator enables
  logic int_mode;
  assign int_mode = (mode == fll_engaged_internal) || (mode == fll_bypassed_internal) ||
    (mode == low_power_bypass_internal);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_mode_reg <= fll_engaged_internal;
    end else if (mode != stop_mode) begin
      run_mode_reg <= mode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fll_enable <= 1'b1;
      pll_enable <= 1'b0;
      int_ref_enable <= 1'b1;
      osc_enable <= 1'b0;
      osc_range <= 1'b0;
      osc_high_gain <= 1'b0;
      int_ref_trim <= TRIM_RST;
      vco_divide <= MULT_RST;
    end else begin
      fll_enable <= (mode == fll_engaged_internal) || (mode == fll_engaged_external) ||
        (mode == fll_bypassed_internal) || (mode == fll_bypassed_external);
      pll_enable <= (mode == pll_engaged_external) || (mode == pll_bypassed_external);
      if (mode == stop_mode) begin
        int_ref_enable <= ctrl1_reg[IREFSTEN_POS] & (ctrl1_reg[IRCLKEN_POS] |
          (run_mode_reg == fll_engaged_internal) || (run_mode_reg == fll_bypassed_internal) ||
          (run_mode_reg == low_power_bypass_internal));
        osc_enable <= ctrl2_reg[EREFS_POS];
      end else begin
        int_ref_enable <= ctrl1_reg[IRCLKEN_POS] | int_mode | reference_select_bit;
        osc_enable <= ctrl2_reg[EREFS_POS] | ~reference_select_bit |
          (source_select_field == SEL_EXT);
      end
      osc_range <= ctrl2_reg[RANGE_POS];
      osc_high_gain <= ctrl2_reg[HGO_POS];
      int_ref_trim <= trim_reg;
      vco_divide <= mult_reg;
    end
  end

  // Debug clock from the oscillator core
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_half_rate_clock <= 1'b0;
    end else if (dco_e.rise) begin
      debug_half_rate_clock <= ~debug_half_rate_clock;
    end
  end

  // Glitch-free source select and bus divider
  logic [1:0] src_want;
  logic [1:0] div_act_reg;
  logic [2:0] half_cnt_reg;
  logic src_tog;
  logic phase_end;
  logic may_run;
  always_comb begin
    case (source_select_field)
      SEL_INT: src_want = SRC_INT;
      SEL_EXT: src_want = SRC_EXT;
      default: src_want = plls_reg ? SRC_VCO : SRC_DCO;
    endcase
  end

  always_comb begin
    case (src_act_reg)
      SRC_VCO: src_tog = vco_e.toggle;
      SRC_INT: src_tog = int_e.toggle;
      SRC_EXT: src_tog = ext_e.toggle;
      default: src_tog = dco_e.toggle;
    endcase
  end

  assign may_run = (mode != stop_mode) | sys_clk;
  assign phase_end = src_tog & may_run & (half_cnt_reg == 3'((4'h1 << div_act_reg) - 4'h1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk <= 1'b0;
      half_cnt_reg <= '0;
      src_act_reg <= SRC_DCO;
      div_act_reg <= CTRL2_RST[BUS_DIVIDER_POS+:2];
    end else if (phase_end) begin
      sys_clk <= ~sys_clk;
      half_cnt_reg <= '0;
      if (sys_clk) begin
        src_act_reg <= src_want;
        div_act_reg <= bus_divider_field;
      end
    end else if (src_tog && may_run) begin
      half_cnt_reg <= half_cnt_reg + 3'h1;
    end
  end
endmodule

// File: sim/clock_generator_checker.sv
`timescale 1ns/1ns
module clock_generator_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [clock_generator_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [clock_generator_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [clock_generator_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic stop_req,
  input wire logic sys_clk,
  input wire logic [clock_generator_pkg::TRIM_W-1:0] int_ref_trim,
  input wire logic osc_enable,
  input wire logic fll_enable,
  input wire logic pll_enable,
  input wire logic ext_loss_reset_req
);
  import clock_generator_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
  trim_copy_a:
    assert property (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == TRIM_OFS
      && wb_sel_i == 4'hF |=> ##1 int_ref_trim == $past(wb_dat_i[8:0], 2))
      else $error("trim output does not follow write");
  high_phase_a:
    assert property ($rose(sys_clk) |-> sys_clk [*3]) else $error("short high phase");
  stop_low_a:
    assert property (stop_req && $fell(sys_clk) |-> !sys_clk [*6])
      else $error("system clock runs in stop");
  loop_excl_a:
    assert property (!(fll_enable && pll_enable)) else $error("both loops enabled");
  loss_sticky_a:
    assert property (ext_loss_reset_req |=> ext_loss_reset_req) else $error("loss request dropped");
  loss_cause_a:
    assert property ($rose(ext_loss_reset_req) |-> $past(osc_enable))
      else $error("loss request without oscillator");
endmodule
bind clock_generator clock_generator_checker i_clock_generator_checker (.ref_clk, .rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .stop_req, .sys_clk, .int_ref_trim, .osc_enable, .fll_enable, .pll_enable,
  .ext_loss_reset_req);

// File: sim/clock_sources.sv
`timescale 1ns/1ns
module clock_sources (
  input wire logic osc_enable,
  input wire logic ext_run,
  output logic int_ref_clk,
  output logic ext_ref_clk,
  output logic dco_clk,
  output logic vco_clk,
  output logic osc_ready
);
  // Edges kept clear of the block clock edges
  initial begin
    int_ref_clk = 1'b0;
    #10;
    forever #300 int_ref_clk = ~int_ref_clk;
  end
  // Crystal clock, stands still when lost
  initial begin
    ext_ref_clk = 1'b0;
    #10;
    forever begin
      #250;
      if (ext_run) ext_ref_clk = ~ext_ref_clk;
    end
  end
  initial begin
    dco_clk = 1'b0;
    #10;
    forever #200 dco_clk = ~dco_clk;
  end
  initial begin
    vco_clk = 1'b0;
    #10;
    forever #350 vco_clk = ~vco_clk;
  end
  // Oscillator start-up after enable
  initial osc_ready = 1'b0;
  always @(osc_enable) osc_ready <= #1000 osc_enable;
endmodule

// File: sim/clock_generator_test.sv
`timescale 1ns/1ns
module clock_generator_test;
  import clock_generator_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, int_ref_clk, ext_ref_clk, dco_clk, vco_clk, osc_ready, sys_clk;
  logic debug_half_rate_clock, int_ref_enable, osc_enable, osc_range, osc_high_gain;
  logic fll_enable, pll_enable, irq, ext_loss_reset_req;
  logic [8:0] int_ref_trim;
  logic [7:0] dco_adjust, vco_divide;
  logic stop_req = 1'b0;
  logic ext_run = 1'b1;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] q;
  clock_generator i_clock_generator (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .int_ref_clk, .ext_ref_clk,
    .dco_clk, .vco_clk, .osc_ready, .stop_req, .sys_clk, .debug_half_rate_clock,
    .int_ref_trim, .int_ref_enable, .osc_enable, .osc_range, .osc_high_gain, .fll_enable,
    .pll_enable, .dco_adjust, .vco_divide, .irq, .ext_loss_reset_req);
  clock_sources i_clock_sources (.osc_enable, .ext_run, .int_ref_clk, .ext_ref_clk,
    .dco_clk, .vco_clk, .osc_ready);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // One classic cycle; waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge ref_clk);
      t++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    chk("ack wait", 32'h2, t);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  // Cycles between two rising edges of sys_clk or debug clock
  task automatic gap(input logic dbg, output logic [31:0] n);
    logic p, c;
    int k, s, g;
    p = 1'b1;
    k = 0;
    s = 0;
    g = 0;
    n = 32'h0;
    while (s < 3 && g < 800) begin
      @(posedge ref_clk);
      c = dbg ? debug_half_rate_clock : sys_clk;
      k++;
      g++;
      if (c === 1'b1 && p === 1'b0) begin
        if (s == 2) n = k;
        s++;
        k = 0;
      end
      p = c;
    end
  endtask
  task automatic t_reset;
    chk("trim out", 32'h100, int_ref_trim);
    chk("dco adjust", 32'h80, dco_adjust);
    chk("vco divide", 32'h20, vco_divide);
    chk("loops", 32'h2, {fll_enable, pll_enable});
    chk("int ref en", 32'h1, int_ref_enable);
    rdc("ctrl1", CTRL1_OFS, 32'hFF, 32'h04);
    rdc("ctrl2", CTRL2_OFS, 32'hFF, 32'h40);
    rdc("trim", TRIM_OFS, 32'h1FF, 32'h100);
    rdc("status", STATUS_OFS, 32'h4F, 32'h40);
    rdc("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_trim;
    wb(1'b1, TRIM_OFS, 32'h1FF);
    repeat (2) @(posedge ref_clk);
    chk("trim out", 32'h1FF, int_ref_trim);
    wb(1'b1, TRIM_OFS, 32'h0AA);
    rdc("trim", TRIM_OFS, 32'h1FF, 32'h0AA);
    wb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
    wb(1'b1, 8'h1C, 32'hFFFFFFFF);
    rdc("status ro", STATUS_OFS, 32'h4F, 32'h40);
    $display("trim test done");
  endtask
  task automatic t_source;
    logic [31:0] n;
    logic [31:0] ex [4];
    ex = '{32'h8, 32'hC, 32'hA, 32'h8};
    wb(1'b1, CTRL2_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, CTRL1_OFS, {24'h0, i[1:0], 6'h04});
      gap(1'b0, n);
      gap(1'b0, n);
      chk("sys period src", ex[i], n);
    end
    wb(1'b1, CTRL1_OFS, 32'h44);
    for (int b = 1; b < 4; b++) begin
      wb(1'b1, CTRL2_OFS, {24'h0, b[1:0], 6'h0});
      gap(1'b0, n);
      gap(1'b0, n);
      chk("sys period div", 32'hC << b, n);
    end
    $display("source test done");
  endtask
  task automatic t_modes;
    logic [31:0] n;
    logic [7:0] tb [8][4];
    tb = '{'{8'h04, 8'h0, 8'h0, 8'h0}, '{8'h00, 8'h0, 8'h0, 8'h1}, '{8'h44, 8'h0, 8'h0, 8'h2},
      '{8'h80, 8'h0, 8'h0, 8'h3}, '{8'h00, 8'h0, 8'h1, 8'h4}, '{8'h80, 8'h0, 8'h1, 8'h5},
      '{8'h44, 8'h8, 8'h0, 8'h6}, '{8'h80, 8'h8, 8'h0, 8'h7}};
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, CTRL1_OFS, {24'h0, tb[i][0]});
      wb(1'b1, CTRL2_OFS, {24'h0, tb[i][1]});
      wb(1'b1, LOOP_OFS, {16'h0, 8'h20, tb[i][2]});
      repeat (4) @(posedge ref_clk);
      rdc("mode", STATUS_OFS, 32'h4F, {25'h0, tb[i][0][2], 2'h0, tb[i][3][3:0]});
      chk("pll en", {31'h0, tb[i][3] == 8'h4 || tb[i][3] == 8'h5}, pll_enable);
      gap(1'b1, n);
      chk("debug period", 32'h10, n);
    end
    stop_req <= 1'b1;
    repeat (60) @(posedge ref_clk);
    chk("stopped clk", 32'h0, sys_clk);
    rdc("stop mode", STATUS_OFS, 32'hF, 32'h8);
    stop_req <= 1'b0;
    wb(1'b1, CTRL1_OFS, 32'h3C);
    rdc("ref div", CTRL1_OFS, 32'hFF, 32'h3C);
    $display("mode test done");
  endtask
  // External reference divided by 8 gives 5 or 6 VCO rises per tick
  task automatic t_lock;
    wb(1'b1, CTRL2_OFS, 32'h0);
    wb(1'b1, CTRL1_OFS, 32'h18);
    wb(1'b1, LOOP_OFS, 32'h0601);
    repeat (600) @(posedge ref_clk);
    rdc("lock", STATUS_OFS, 32'h1F, 32'h14);
    rdc("lock irq", IRQ_STAT_OFS, 32'h3, 32'h1);
    wb(1'b1, LOOP_OFS, 32'h0600);
    repeat (3) @(posedge ref_clk);
    rdc("unlock irq", IRQ_STAT_OFS, 32'h3, 32'h3);
    $display("lock test done");
  endtask
  task automatic t_loss;
    wb(1'b1, CTRL1_OFS, 32'h04);
    wb(1'b1, LOOP_OFS, 32'h2000);
    wb(1'b1, IRQ_STAT_OFS, 32'h7);
    wb(1'b1, IRQ_MASK_OFS, 32'h0);
    wb(1'b1, CTRL2_OFS, 32'h36);
    repeat (2) @(posedge ref_clk);
    chk("osc ctl", 32'h7, {osc_enable, osc_range, osc_high_gain});
    ext_run <= 1'b0;
    repeat (1900) @(posedge ref_clk);
    chk("loss early", 32'h0, ext_loss_reset_req);
    repeat (200) @(posedge ref_clk);
    chk("loss req", 32'h1, ext_loss_reset_req);
    chk("irq masked", 32'h0, irq);
    rdc("irq stat", IRQ_STAT_OFS, 32'h4, 32'h4);
    rdc("osc ready", STATUS_OFS, 32'h20, 32'h20);
    wb(1'b1, IRQ_MASK_OFS, 32'h4);
    repeat (3) @(posedge ref_clk);
    chk("irq on", 32'h1, irq);
    ext_run <= 1'b1;
    repeat (20) @(posedge ref_clk);
    wb(1'b1, IRQ_STAT_OFS, 32'h4);
    repeat (3) @(posedge ref_clk);
    chk("irq off", 32'h0, irq);
    rdc("irq clear", IRQ_STAT_OFS, 32'h4, 32'h0);
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("loss reset", 32'h0, ext_loss_reset_req);
    $display("monitor test done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_trim();
    t_source();
    t_modes();
    t_lock();
    t_loss();
    close_out();
  end
endmodule
